// [inc/gpio_pad_consts.svh]
/*
  Register addresses, field positions, writable masks and reset values for the
  three-port pad and data register block. Assumes byte addressing on a 32-bit bus.
*/
`ifndef GPIO_PAD_CONSTS_SVH
`define GPIO_PAD_CONSTS_SVH

`define P0_DAT_ADDR 32'hFFFFF420
`define P0_SET_ADDR 32'hFFFFF424
`define P0_CLR_ADDR 32'hFFFFF428
`define P0_PAR_ADDR 32'hFFFFF42C
`define P1_DAT_ADDR 32'hFFFFF430
`define P1_SET_ADDR 32'hFFFFF434
`define P1_CLR_ADDR 32'hFFFFF438
`define P1_PAR_ADDR 32'hFFFFF43C
`define P2_DAT_ADDR 32'hFFFFF440
`define P2_SET_ADDR 32'hFFFFF444
`define P2_CLR_ADDR 32'hFFFFF448
`define P2_PAR_ADDR 32'hFFFFF44C

`define DAT_DIR_LSB 24
`define DAT_OUT_LSB 16
`define DAT_RST_LSB 8
`define DAT_IN_LSB 0

`define PAR_PIN_STRIDE 4
`define PAR_PU_BIT 0
`define PAR_DRV_LSB 1

`define DRV_MED 2'h0
`define DRV_LOW 2'h1

`define P0_PAR_RST 32'h22220000
`define P1_PAR_RST 32'h22000022
`define P2_PAR_RST 32'h00000000

`define P0_PU_WR_MASK 8'hF9
`define P1_PU_WR_MASK 8'hFF
`define P2_PU_WR_MASK 8'h1C
`define P0_DRV_WR_MASK 8'hE0
`define P1_DRV_WR_MASK 8'hC0
`define P2_DRV_WR_MASK 8'h00

`define TAP_PIN_MASK_DEF 8'h0F

`endif

// [inc/gpio_pad_pkg.sv]
/*
  Types for the pad and data register block: register kinds, decoded address,
  per-pin drive strength and the pad control bundle of one port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gpio_pad_pkg;

  typedef enum logic [2:0] {REG_DAT, REG_SET, REG_CLR, REG_PAR, REG_NONE} reg_kind_e;

  typedef struct packed {
    logic hit;
    logic [1:0] port;
    reg_kind_e kind;
  } reg_sel_s;

  typedef struct packed {
    logic high;
    logic med;
    logic low;
  } strength_s;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] pull_en;
    strength_s [7:0] drive;
  } pad_s;

endpackage

// [hw/gpio_port_pad_and_data_regs.sv]
/*
  Three 8-pin ports: direction/output/data, set, clear and pad parameter
  registers behind a classic Wishbone slave, plus registered pad controls.
  Assumes pin inputs synchronous to REF_CLK_I and byte addresses on ADR_I.
*/
// The Wishbone slave port is this design's own decision.
// Function
// [RULE1] pad word per pin n: pull-up disable at 4n, drive strength at 4n+2..4n+1
// [RULE2] drive code 00 medium, 01 low, 1x high
// [RULE3] only the first drive strength write after reset is taken
// [RULE4] port 0 drive fields of pins 0,3,4 read zero; pins 1,2 reserved
// [RULE5] port 1 drive fields of pins 0..5 read zero; all pull-ups writable
// [RULE6] port 2: only pull-ups of pins 2,3,4 writable, rest zero
// [RULE7] port 2 pin 0 analog keeps its pull-up on
// [RULE8] software writes the data register after changing pad parameters
// [RULE9] data bits 31..24 set direction, 1 is output
// [RULE10] data bits 23..16 hold output values
// [RULE11] data bits 15..8 show pin levels caught at reset
// [RULE12] data bits 7..0 show live pin levels
// [RULE13] set register ones in 23..16 set output bits
// [RULE14] set register zeros change nothing; other bits reserved
// [RULE15] set and clear registers are write-only, acting on outputs only
// [RULE16] clear register ones in 23..16 clear output bits
// [RULE17] test access port pins cannot be driven as general I/O
// [RULE18] reserved and fixed bits ignore writes and read fixed values
`include "gpio_pad_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module gpio_port_pad_and_data_regs #(
  parameter logic [7:0] TAP_PIN_MASK = `TAP_PIN_MASK_DEF,
  parameter int PINS = 8
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [31:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic [7:0] P0_PIN_I,
  input wire logic [7:0] P1_PIN_I,
  input wire logic [7:0] P2_PIN_I,
  input wire logic TAP_EN_I,
  input wire logic P2_PIN0_ANALOG_I,
  output var gpio_pad_pkg::pad_s P0_PAD_O,
  output var gpio_pad_pkg::pad_s P1_PAD_O,
  output var gpio_pad_pkg::pad_s P2_PAD_O
);

  if (PINS != 8) begin : g_chk
    $error("port width must be 8 pins");
  end

  function automatic logic [31:0] reg_addr(input logic [1:0] p, input logic [1:0] k);
    case ({p, k})
      4'h0: reg_addr = `P0_DAT_ADDR;
      4'h1: reg_addr = `P0_SET_ADDR;
      4'h2: reg_addr = `P0_CLR_ADDR;
      4'h3: reg_addr = `P0_PAR_ADDR;
      4'h4: reg_addr = `P1_DAT_ADDR;
      4'h5: reg_addr = `P1_SET_ADDR;
      4'h6: reg_addr = `P1_CLR_ADDR;
      4'h7: reg_addr = `P1_PAR_ADDR;
      4'h8: reg_addr = `P2_DAT_ADDR;
      4'h9: reg_addr = `P2_SET_ADDR;
      4'hA: reg_addr = `P2_CLR_ADDR;
      4'hB: reg_addr = `P2_PAR_ADDR;
      default: reg_addr = 32'h00000000;
    endcase
  endfunction

  function automatic gpio_pad_pkg::reg_sel_s decode(input logic [31:0] a);
    decode = '{hit: 1'b0, port: 2'h0, kind: gpio_pad_pkg::REG_NONE};
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 4; k++) begin
        if (a == reg_addr(2'(p), 2'(k))) begin
          decode.hit = 1'b1;
          decode.port = 2'(p);
          decode.kind = gpio_pad_pkg::reg_kind_e'(3'(k));
        end
      end
    end
  endfunction

  function automatic logic [7:0] pu_wr_mask(input logic [1:0] p);
    case (p)
      2'h0: pu_wr_mask = `P0_PU_WR_MASK;
      2'h1: pu_wr_mask = `P1_PU_WR_MASK;
      2'h2: pu_wr_mask = `P2_PU_WR_MASK;
      default: pu_wr_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] drv_wr_mask(input logic [1:0] p);
    case (p)
      2'h0: drv_wr_mask = `P0_DRV_WR_MASK;
      2'h1: drv_wr_mask = `P1_DRV_WR_MASK;
      2'h2: drv_wr_mask = `P2_DRV_WR_MASK;
      default: drv_wr_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [31:0] par_rst(input logic [1:0] p);
    case (p)
      2'h0: par_rst = `P0_PAR_RST;
      2'h1: par_rst = `P1_PAR_RST;
      default: par_rst = `P2_PAR_RST;
    endcase
  endfunction

  function automatic logic [15:0] spread(input logic [7:0] m);
    for (int i = 0; i < 8; i++) begin
      spread[2*i +: 2] = {2{m[i]}};
    end
  endfunction

  function automatic logic [7:0] get_pu(input logic [31:0] w);
    for (int i = 0; i < 8; i++) begin
      get_pu[i] = w[`PAR_PIN_STRIDE*i + `PAR_PU_BIT];
    end
  endfunction

  function automatic logic [15:0] get_drv(input logic [31:0] w);
    for (int i = 0; i < 8; i++) begin
      get_drv[2*i +: 2] = w[`PAR_PIN_STRIDE*i + `PAR_DRV_LSB +: 2];
    end
  endfunction

  // reserved bits stay zero
  function automatic logic [31:0] pack_par(input logic [7:0] pu, input logic [15:0] drv);
    pack_par = 32'h00000000;
    for (int i = 0; i < 8; i++) begin
      pack_par[`PAR_PIN_STRIDE*i + `PAR_PU_BIT] = pu[i]; // [RULE1] [RULE18]
      pack_par[`PAR_PIN_STRIDE*i + `PAR_DRV_LSB +: 2] = drv[2*i +: 2];
    end
  endfunction

  function automatic gpio_pad_pkg::strength_s drive_decode(input logic [1:0] c);
    drive_decode.high = c[1]; // [RULE2]
    drive_decode.med = (c == `DRV_MED);
    drive_decode.low = (c == `DRV_LOW);
  endfunction

  logic [7:0] pin_i [3];
  logic [7:0] dir_q [3];
  logic [7:0] out_q [3];
  logic [7:0] rst_lvl_q [3];
  logic [7:0] pu_q [3];
  logic [15:0] drv_q [3];
  logic [7:0] app_pu_q [3];
  logic [15:0] app_drv_q [3];
  logic [2:0] drv_locked_q;
  logic caught_q;
  logic ack_q;
  logic [31:0] rdat_q;
  gpio_pad_pkg::pad_s pad_q [3];
  gpio_pad_pkg::reg_sel_s sel;
  logic acc;
  logic wr;
  logic [31:0] bm;
  logic [31:0] wd;
  logic [7:0] wbyte_out;
  logic [31:0] rd_word;

  assign pin_i[0] = P0_PIN_I;
  assign pin_i[1] = P1_PIN_I;
  assign pin_i[2] = P2_PIN_I;
  assign sel = decode(ADR_I);
  assign acc = CYC_I & STB_I & ~ack_q;
  assign wr = acc & WE_I & sel.hit;
  assign bm = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  assign wd = DAT_I & bm;
  assign wbyte_out = wd[`DAT_OUT_LSB +: 8];

  always_comb begin
    case (sel.kind)
      gpio_pad_pkg::REG_DAT: rd_word = {dir_q[sel.port], out_q[sel.port],
                                        rst_lvl_q[sel.port], pin_i[sel.port]}; // [RULE11] [RULE12]
      gpio_pad_pkg::REG_PAR: rd_word = pack_par(pu_q[sel.port], drv_q[sel.port]);
      default: rd_word = 32'h00000000; // [RULE15]
    endcase
  end

  // one-cycle answer; unmapped addresses still ack and read zero
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= acc;
      rdat_q <= (acc && !WE_I && sel.hit) ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int p = 0; p < 3; p++) begin
        dir_q[p] <= 8'h00;
        out_q[p] <= 8'h00;
      end
    end else if (wr) begin
      for (int p = 0; p < 3; p++) begin
        if (sel.port == 2'(p)) begin
          case (sel.kind)
            gpio_pad_pkg::REG_DAT: begin
              dir_q[p] <= (dir_q[p] & ~bm[`DAT_DIR_LSB +: 8]) | wd[`DAT_DIR_LSB +: 8]; // [RULE9]
              out_q[p] <= (out_q[p] & ~bm[`DAT_OUT_LSB +: 8]) | wbyte_out; // [RULE10]
            end
            gpio_pad_pkg::REG_SET: out_q[p] <= out_q[p] | wbyte_out; // [RULE13] [RULE14]
            gpio_pad_pkg::REG_CLR: out_q[p] <= out_q[p] & ~wbyte_out; // [RULE16]
            default: out_q[p] <= out_q[p];
          endcase
        end
      end
    end
  end

  // fixed fields never take write data, so they keep their zero
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int p = 0; p < 3; p++) begin
        pu_q[p] <= get_pu(par_rst(2'(p))) & pu_wr_mask(2'(p));
        drv_q[p] <= get_drv(par_rst(2'(p))) & spread(drv_wr_mask(2'(p)));
      end
      drv_locked_q <= 3'h0;
    end else if (wr && sel.kind == gpio_pad_pkg::REG_PAR) begin
      for (int p = 0; p < 3; p++) begin
        if (sel.port == 2'(p)) begin
          pu_q[p] <= (pu_q[p] & ~(get_pu(bm) & pu_wr_mask(2'(p))))
                     | (get_pu(wd) & pu_wr_mask(2'(p))); // [RULE4] [RULE5] [RULE6] [RULE18]
          if (!drv_locked_q[p]) begin
            drv_q[p] <= (drv_q[p] & ~(get_drv(bm) & spread(drv_wr_mask(2'(p)))))
                        | (get_drv(wd) & spread(drv_wr_mask(2'(p)))); // [RULE4] [RULE5] [RULE6]
          end
          drv_locked_q[p] <= 1'b1; // [RULE3]
        end
      end
    end
  end

  // strap-style capture on the first edge after release
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      caught_q <= 1'b0;
      for (int p = 0; p < 3; p++) begin
        rst_lvl_q[p] <= 8'h00;
      end
    end else if (!caught_q) begin
      caught_q <= 1'b1;
      for (int p = 0; p < 3; p++) begin
        rst_lvl_q[p] <= pin_i[p]; // [RULE11]
      end
    end
  end

  // pad settings reach the pins only on a data register write
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int p = 0; p < 3; p++) begin
        app_pu_q[p] <= get_pu(par_rst(2'(p))) & pu_wr_mask(2'(p));
        app_drv_q[p] <= get_drv(par_rst(2'(p))) & spread(drv_wr_mask(2'(p)));
      end
    end else if (wr && sel.kind == gpio_pad_pkg::REG_DAT) begin
      for (int p = 0; p < 3; p++) begin
        if (sel.port == 2'(p)) begin
          app_pu_q[p] <= pu_q[p]; // [RULE8]
          app_drv_q[p] <= drv_q[p];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int p = 0; p < 3; p++) begin
        pad_q[p] <= '0;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        pad_q[p].oe <= dir_q[p] & ((p == 0 && TAP_EN_I) ? ~TAP_PIN_MASK : 8'hFF); // [RULE9] [RULE17]
        pad_q[p].out <= out_q[p]; // [RULE10]
        pad_q[p].pull_en <= ~app_pu_q[p];
        for (int i = 0; i < 8; i++) begin
          pad_q[p].drive[i] <= drive_decode(app_drv_q[p][2*i +: 2]); // [RULE2]
        end
      end
      if (P2_PIN0_ANALOG_I) begin
        pad_q[2].pull_en[0] <= 1'b1; // [RULE7]
      end
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = rdat_q;
  assign P0_PAD_O = pad_q[0];
  assign P1_PAD_O = pad_q[1];
  assign P2_PAD_O = pad_q[2];

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence wr_kind_s(logic [1:0] p, gpio_pad_pkg::reg_kind_e k);
    wr && sel.port == p && sel.kind == k;
  endsequence

  sequence rd_kind_s(logic [1:0] p, gpio_pad_pkg::reg_kind_e k);
    acc && !WE_I && sel.hit && sel.port == p && sel.kind == k;
  endsequence

  ack_pulse_a: assert property (acc |=> ACK_O ##1 !ACK_O)
    else $error("ack not a single-cycle pulse");
  set_out_a: assert property (wr_kind_s(2'h0, gpio_pad_pkg::REG_SET) |=> // [RULE13]
    (out_q[0] & $past(wbyte_out)) == $past(wbyte_out))
    else $error("set register did not set output bits");
  set_keep_a: assert property (wr_kind_s(2'h2, gpio_pad_pkg::REG_SET) |=> // [RULE14]
    (out_q[2] & ~$past(wbyte_out)) == ($past(out_q[2]) & ~$past(wbyte_out)))
    else $error("set register zero bits changed outputs");
  clr_out_a: assert property (wr_kind_s(2'h1, gpio_pad_pkg::REG_CLR) |=> // [RULE16]
    (out_q[1] & $past(wbyte_out)) == 8'h00)
    else $error("clear register did not clear output bits");
  drv_lock_a: assert property (drv_locked_q[0] ##0 wr_kind_s(2'h0, gpio_pad_pkg::REG_PAR) // [RULE3]
    |=> $stable(drv_q[0]))
    else $error("drive strength changed after first write");
  fixed_fields_a: assert property ((drv_q[0] & ~spread(`P0_DRV_WR_MASK)) == 16'h0000 // [RULE4] [RULE5] [RULE6]
    && (drv_q[1] & ~spread(`P1_DRV_WR_MASK)) == 16'h0000 && drv_q[2] == 16'h0000
    && (pu_q[0] & ~`P0_PU_WR_MASK) == 8'h00 && (pu_q[2] & ~`P2_PU_WR_MASK) == 8'h00)
    else $error("fixed pad field not zero");
  par_read_a: assert property (rd_kind_s(2'h1, gpio_pad_pkg::REG_PAR) |=> // [RULE1]
    DAT_O[`PAR_PIN_STRIDE*7 + `PAR_PU_BIT] == $past(pu_q[1][7]) && DAT_O[31] == 1'b0)
    else $error("pad word read layout wrong");
  analog_pu_a: assert property (P2_PIN0_ANALOG_I |=> P2_PAD_O.pull_en[0]) // [RULE7]
    else $error("analog pin lost its pull-up");
  tap_block_a: assert property (TAP_EN_I |=> (P0_PAD_O.oe & TAP_PIN_MASK) == 8'h00) // [RULE17]
    else $error("test port pin driven as general I/O");
  dir_oe_a: assert property (!TAP_EN_I |=> P1_PAD_O.oe == $past(dir_q[1])) // [RULE9]
    else $error("output enable does not follow direction");
  in_read_a: assert property (rd_kind_s(2'h0, gpio_pad_pkg::REG_DAT) |=> // [RULE12]
    DAT_O[`DAT_IN_LSB +: 8] == $past(P0_PIN_I))
    else $error("live input not returned");
  pad_apply_a: assert property (wr_kind_s(2'h1, gpio_pad_pkg::REG_DAT) ##1 1'b1 |=> // [RULE8]
    P1_PAD_O.drive[7].high == $past(drv_q[1][15], 2))
    else $error("pad setting not applied on data write");

endmodule

`default_nettype wire

// [tb/gpio_pin_model.sv]
/*
  Board side of one 8-pin port: pads driven by the block, pull-ups, board levels.
  Assumes pad controls from the block and a board level per pin from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_model (
  input var gpio_pad_pkg::pad_s pad_i,
  input wire logic [7:0] board_i,
  output logic [7:0] pin_o
);
  // released pins fall back to the pull-up, else to whatever the board holds
  assign pin_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & (pad_i.pull_en | board_i));
endmodule
`default_nettype wire

// [tb/test_gpio_port_pad_and_data_regs.sv]
/*
  Self-checking bench for the three-port pad and data register block.
  Assumes the pin model beside it and a 100 MHz clock; reads checked from a queue.
*/
`include "gpio_pad_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module test_gpio_port_pad_and_data_regs;
  logic clk, rst_n, cyc, stb, we, tap, ana, ack;
  logic [3:0] sel;
  logic [31:0] adr, wdat, rdat, r;
  logic [7:0] pin0, pin1, pin2;
  logic [7:0] brd [3];
  logic [7:0] dir [3];
  logic [7:0] outv [3];
  logic [7:0] rst [3];
  logic [31:0] par [3];
  logic [31:0] app [3];
  logic [32:0] exp_q [$];
  logic [32:0] mon_e;
  gpio_pad_pkg::pad_s pad0, pad1, pad2;
  int err_count = 0;
  int checks_done = 0;
  int seed = 76;
  logic [31:0] w1 [3] = '{32'h55511001, 32'h4AFFFFFF, 32'h00000000};
  logic [31:0] e1 [3] = '{32'h55511001, 32'h42111111, 32'h00000000};
  logic [31:0] e2 [3] = '{32'h55511001, 32'h53111111, 32'h00011100};

  gpio_port_pad_and_data_regs dut (.REF_CLK_I(clk), .RSTN_I(rst_n), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .P0_PIN_I(pin0), .P1_PIN_I(pin1), .P2_PIN_I(pin2), .TAP_EN_I(tap),
    .P2_PIN0_ANALOG_I(ana), .P0_PAD_O(pad0), .P1_PAD_O(pad1), .P2_PAD_O(pad2));
  gpio_pin_model m0 (.pad_i(pad0), .board_i(brd[0]), .pin_o(pin0));
  gpio_pin_model m1 (.pad_i(pad1), .board_i(brd[1]), .pin_o(pin1));
  gpio_pin_model m2 (.pad_i(pad2), .board_i(brd[2]), .pin_o(pin2));

  always #5 clk = ~clk;

  function automatic logic [31:0] ra(input int p, input int k);
    return `P0_DAT_ADDR + 32'(16 * p + 4 * k);
  endfunction
  function automatic logic [2:0] drv(input logic [1:0] c);
    return c[1] ? 3'h4 : (c[0] ? 3'h1 : 3'h2);
  endfunction
  function automatic logic [7:0] pen_of(input logic [31:0] w);
    for (int i = 0; i < 8; i++) pen_of[i] = ~w[4 * i];
  endfunction
  // analog use of port 2 pin 0 keeps its pull-up whatever the stored bit says
  function automatic logic [7:0] pen_exp(input int p);
    return pen_of(app[p]) | ((p == 2 && ana) ? 8'h01 : 8'h00);
  endfunction
  function automatic logic [7:0] oe_of(input int p);
    return dir[p] & ~((p == 0 && tap) ? 8'h0F : 8'h00);
  endfunction
  function automatic logic [31:0] dat_of(input int p);
    logic [7:0] oe;
    oe = oe_of(p);
    return {dir[p], outv[p], rst[p], (oe & outv[p]) | (~oe & (pen_exp(p) | brd[p]))};
  endfunction

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pad(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one access at a time; the slave's answer time is never assumed, the watchdog ends a hang
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    chk_pad("ack low", 8'h00, {7'h00, ack});
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 33'h000000000);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h00000000, {1'b1, e});
  endtask

  always @(posedge clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("mismatch ack expected none seen 1");
      end else begin
        mon_e = exp_q.pop_front();
        if (mon_e[32]) chk_reg("read data", mon_e[31:0], rdat);
      end
    end
  end

  task automatic chk_pads(input int p);
    gpio_pad_pkg::pad_s pd;
    pd = (p == 0) ? pad0 : ((p == 1) ? pad1 : pad2);
    chk_pad("oe", oe_of(p), pd.oe);
    chk_pad("out", outv[p], pd.out);
    chk_pad("pull_en", pen_exp(p), pd.pull_en);
    for (int i = 0; i < 8; i++) begin
      chk_pad("drive", {5'h00, drv(app[p][4 * i + 1 +: 2])}, {5'h00, pd.drive[i]});
    end
  endtask

  // board levels stay put through reset so the caught levels are known
  task automatic reset_dut();
    @(posedge clk);
    rst_n <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      r = $random(seed);
      brd[p] <= r[7:0];
      rst[p] = r[7:0];
      dir[p] = 8'h00;
      outv[p] = 8'h00;
    end
    // fixed-zero drive fields win over the printed reset words
    par = '{32'h22200000, 32'h22000000, 32'h00000000};
    app = par;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    $display("mismatch watchdog expected done seen hang");
    complete_run();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    tap = 1'b0;
    ana = 1'b0;
    sel = 4'hF;
    adr = 32'h00000000;
    wdat = 32'h00000000;
    brd = '{8'h00, 8'h00, 8'h00};
    reset_dut();
    for (int p = 0; p < 3; p++) begin
      rd(ra(p, 3), par[p]);
      rd(ra(p, 0), dat_of(p));
      rd(ra(p, 1), 32'h00000000);
      rd(ra(p, 2), 32'h00000000);
      chk_pads(p);
    end
    rd(32'hFFFFF450, 32'h00000000);
    $display("test reset finished");
    for (int p = 0; p < 3; p++) begin
      wr(ra(p, 3), w1[p]);
      par[p] = e1[p];
      rd(ra(p, 3), par[p]);
      wr(ra(p, 3), 32'hFFFFFFFF);
      par[p] = e2[p];
      rd(ra(p, 3), par[p]);
      repeat (2) @(posedge clk);
      chk_pads(p);
      r = $random(seed);
      dir[p] = r[31:24];
      outv[p] = r[23:16];
      wr(ra(p, 0), {r[31:16], 16'hFFFF});
      app[p] = par[p];
      repeat (2) @(posedge clk);
      chk_pads(p);
      rd(ra(p, 0), dat_of(p));
    end
    $display("test pad finished");
    for (int p = 0; p < 3; p++) begin
      r = $random(seed);
      brd[p] <= r[7:0];
      r = $random(seed);
      wr(ra(p, 1), r);
      outv[p] = outv[p] | r[23:16];
      r = $random(seed);
      wr(ra(p, 2), r);
      outv[p] = outv[p] & ~r[23:16];
      repeat (2) @(posedge clk);
      chk_pads(p);
      rd(ra(p, 0), dat_of(p));
    end
    // only the output byte enabled: direction must survive the write
    sel <= 4'h4;
    r = $random(seed);
    wr(ra(0, 0), r);
    outv[0] = r[23:16];
    sel <= 4'hF;
    rd(ra(0, 0), dat_of(0));
    $display("test setclear finished");
    tap <= 1'b1;
    ana <= 1'b1;
    repeat (3) @(posedge clk);
    chk_pads(0);
    chk_pads(2);
    rd(ra(0, 0), dat_of(0));
    tap <= 1'b0;
    ana <= 1'b0;
    $display("test tap finished");
    reset_dut();
    rd(ra(0, 3), par[0]);
    wr(ra(0, 3), 32'hFFFFFFFF);
    par[0] = 32'h77711001;
    rd(ra(0, 3), par[0]);
    rd(ra(1, 0), dat_of(1));
    $display("test rereset finished");
    complete_run();
  end
endmodule
`default_nettype wire
